// ==== core/pra_arq.sv ====
// packet retry engine, duplicate filter, hop control and line arbiter
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pra_arq #(
   parameter int unsigned ACK_WAIT_CYC = pra_pkg::ACK_WAIT_CYC,
   parameter int unsigned RW_A_CYC     = pra_pkg::RW_A_CYC,
   parameter int unsigned RW_B_CYC     = pra_pkg::RW_B_CYC,
   parameter int unsigned RW_C_CYC     = pra_pkg::RW_C_CYC
) (
   input  wire logic       clk_i,                 // 40 MHz clock
   input  wire logic       resetn_i,              // async reset, active low
   input  wire logic [7:0] addr_i,                // register byte address
   input  wire logic [31:0] wdata_i,              // register write data
   input  wire logic       wr_i,                  // write strobe
   input  wire logic       rd_i,                  // read strobe
   output logic [31:0]     rdata_o,               // read data, cycle after rd_i
   input  wire logic       send_direct_cmd_i,     // terminal send, pulse
   input  wire logic       send_via_relay_cmd_i,  // terminal send via repeater, pulse
   input  wire logic       cmd_bcast_i,           // qualifies send as broadcast
   input  wire logic       retry_set_cmd_i,       // retry setting command, pulse
   input  wire logic [7:0] retry_val_i,           // value for retry_set_cmd_i
   input  wire logic       relay_fwd_i,           // packet to forward as repeater
   input  wire logic       carrier_i,             // channel busy
   input  wire logic       radio_done_i,          // radio finished sending
   input  wire logic       ack_start_i,           // ack preamble seen
   input  wire logic       ack_rx_i,              // ack packet received
   input  wire logic       ack_abort_i,           // ack reception broke off
   input  wire logic       rx_pkt_i,              // data packet received, pulse
   input  wire logic       rx_bcast_i,            // received packet is broadcast
   input  wire logic [7:0] rx_tag_i,              // packet identity tag
   input  wire logic       line_act_i,            // rs485 line activity pin
   input  wire logic       ser_pending_i,         // terminal data waiting for line
   output logic            radio_tx_o,            // start radio send, pulse
   output logic            ack_tx_o,              // send ack packet, pulse
   output logic            deliver_o,             // deliver rx data, pulse
   output logic            success_response_o,    // success to terminal, pulse
   output logic            failure_response_o,    // failure to terminal, pulse
   output logic [4:0]      freq_o,                // current group frequency
   output logic            busy_o,                // transfer in progress
   output logic            ser_grant_o,           // own line output allowed
   output logic            sync_o,                // emit sync char, pulse
   output logic [7:0]      sync_char_o            // sync char while sync_o
);
   function automatic logic [4:0] next_freq(input logic [4:0] f, input logic [4:0] n);
      next_freq = (f + 5'd1 >= n) ? 5'd0 : f + 5'd1;
   endfunction
   function automatic logic [19:0] rwait_len(input logic [1:0] s);
      rwait_len = (s == 2'd0) ? 20'd0 : (s == 2'd1) ? 20'(RW_A_CYC - 1) :
                  (s == 2'd2) ? 20'(RW_B_CYC - 1) : 20'(RW_C_CYC - 1);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   pra_pkg::pra_state_t st_r, st_nxt;
   logic [19:0] tmr_r, tmr_nxt;
   logic [7:0]  left_r, left_nxt, retry_r, retry_nxt, tag_r, tag_nxt, lfsr_r, lfsr_nxt;
   logic        bcast_r, bcast_nxt, relay_r, relay_nxt, seen_r, seen_nxt, tagv_r, tagv_nxt;
   logic [4:0]  freq_r, freq_nxt, gsize_r, gsize_nxt;
   logic [15:0] dwc_r, dwc_nxt, ival_r, ival_nxt, dwell_r, dwell_nxt, cnt_r, cnt_nxt;
   logic [2:0]  opt_r, opt_nxt;
   logic [5:0]  pre_r, pre_nxt;
   logic        line_m_r, line_s_r, grant_r, grant_nxt, sync_r, sync_nxt;
   logic        rtx_nxt, atx_nxt, dlv_nxt, suc_nxt, fail_nxt;
   logic [31:0] rdata_nxt;
   logic [7:0]  schar_nxt;
   logic        tick, grp_en, coll_en, rx_ok, dup, att_fail, ready;
   logic        busy_r, busy_nxt;

   assign tick    = (pre_r == 6'd0);
   assign grp_en  = opt_r[pra_pkg::OPT_GRP_BIT];
   assign coll_en = opt_r[pra_pkg::OPT_COLL_BIT];
   assign rx_ok   = rx_pkt_i && !(bcast_r && st_r != pra_pkg::ST_IDLE);
   assign dup     = tagv_r && (rx_tag_i == tag_r);
   assign att_fail = (st_r == pra_pkg::ST_ACKW) && ((!seen_r && tmr_r == 20'd0) || (seen_r && ack_abort_i));
   assign ready   = !ser_pending_i && !grant_r && !line_s_r && cnt_r >= ival_r;

   ////////////////////////////////////////////////////////////////////////
   // registers over the plain port
   always_comb begin
      retry_nxt = retry_r;
      ival_nxt  = ival_r;
      opt_nxt   = opt_r;
      gsize_nxt = gsize_r;
      dwell_nxt = dwell_r;
      rdata_nxt = 32'h0000_0000;
      if (wr_i) begin
         unique case (addr_i)
            pra_pkg::ADDR_RETRY: retry_nxt = wdata_i[7:0];
            pra_pkg::ADDR_IVAL:  ival_nxt  = wdata_i[15:0];
            pra_pkg::ADDR_OPT:   opt_nxt   = wdata_i[2:0];
            pra_pkg::ADDR_GSIZE: gsize_nxt = (wdata_i[4:0] == 5'd0) ? 5'd1 : wdata_i[4:0];
            pra_pkg::ADDR_DWELL: dwell_nxt = wdata_i[15:0];
            default: ;
         endcase
      end
      if (retry_set_cmd_i) begin
         retry_nxt = retry_val_i;
      end
      if (rd_i) begin
         unique case (addr_i)
            pra_pkg::ADDR_RETRY:  rdata_nxt = {24'h00_0000, retry_r};
            pra_pkg::ADDR_IVAL:   rdata_nxt = {16'h0000, ival_r};
            pra_pkg::ADDR_OPT:    rdata_nxt = {29'h0000_0000, opt_r};
            pra_pkg::ADDR_GSIZE:  rdata_nxt = {27'h000_0000, gsize_r};
            pra_pkg::ADDR_DWELL:  rdata_nxt = {16'h0000, dwell_r};
            pra_pkg::ADDR_STATUS: rdata_nxt = {12'h000, bcast_r, relay_r, st_r, freq_r, left_r};
            default:              rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit sequencing and receive filtering
   always_comb begin
      st_nxt   = st_r;
      tmr_nxt  = (tmr_r == 20'd0) ? 20'd0 : tmr_r - 20'd1;
      left_nxt = left_r;
      bcast_nxt = bcast_r;
      relay_nxt = relay_r;
      seen_nxt = seen_r;
      freq_nxt = (freq_r >= gsize_r) ? 5'd0 : freq_r;
      dwc_nxt  = dwc_r;
      tag_nxt  = tag_r;
      tagv_nxt = tagv_r;
      lfsr_nxt = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      rtx_nxt  = 1'b0;
      atx_nxt  = 1'b0;
      dlv_nxt  = 1'b0;
      suc_nxt  = 1'b0;
      fail_nxt = 1'b0;
      unique case (st_r)
         pra_pkg::ST_IDLE: begin
            // slower dwell than the sender's hop so the two meet
            if (grp_en && tick) begin
               dwc_nxt = dwc_r + 16'd1;
               if (dwc_r >= dwell_r) begin
                  dwc_nxt  = 16'd0;
                  freq_nxt = next_freq(freq_r, gsize_r);
               end
            end
            if (send_direct_cmd_i || send_via_relay_cmd_i || relay_fwd_i) begin
               left_nxt  = retry_r;
               bcast_nxt = cmd_bcast_i && !relay_fwd_i;
               relay_nxt = relay_fwd_i;
               st_nxt    = pra_pkg::ST_CSNS;
            end
         end
         pra_pkg::ST_RWAIT: st_nxt = (tmr_r == 20'd0) ? pra_pkg::ST_CSNS : st_r;
         pra_pkg::ST_CSNS: begin
            if (carrier_i) begin
               st_nxt  = pra_pkg::ST_RWAIT;
               tmr_nxt = rwait_len(lfsr_r[1:0]);
            end else begin
               rtx_nxt = 1'b1;
               st_nxt  = pra_pkg::ST_SEND;
            end
         end
         pra_pkg::ST_SEND: begin
            if (radio_done_i) begin
               seen_nxt = 1'b0;
               if (bcast_r) begin
                  // broadcast: no ack, count copies only
                  if (left_r <= 8'd1) begin
                     suc_nxt = 1'b1;
                     st_nxt  = pra_pkg::ST_IDLE;
                  end else begin
                     left_nxt = left_r - 8'd1;
                     st_nxt   = pra_pkg::ST_RWAIT;
                     tmr_nxt  = 20'(RW_C_CYC - 1);
                     freq_nxt = grp_en ? next_freq(freq_r, gsize_r) : freq_nxt;
                  end
               end else begin
                  st_nxt  = pra_pkg::ST_ACKW;
                  tmr_nxt = 20'(ACK_WAIT_CYC - 1);
               end
            end
         end
         pra_pkg::ST_ACKW: begin
            seen_nxt = seen_r | ack_start_i;
            if (ack_rx_i) begin
               st_nxt  = pra_pkg::ST_IDLE;
               atx_nxt = relay_r;
               suc_nxt = !relay_r;
            end else if (att_fail) begin
               if (left_r == 8'd0) begin
                  st_nxt   = pra_pkg::ST_IDLE;
                  fail_nxt = !relay_r;
               end else begin
                  left_nxt = left_r - 8'd1;
                  st_nxt   = pra_pkg::ST_RWAIT;
                  tmr_nxt  = rwait_len(lfsr_r[1:0]);
                  freq_nxt = grp_en ? next_freq(freq_r, gsize_r) : freq_nxt;
               end
            end
         end
      endcase
      busy_nxt = (st_nxt != pra_pkg::ST_IDLE);
      if (rx_ok) begin
         atx_nxt = atx_nxt | !rx_bcast_i;
         if (!dup) begin
            dlv_nxt  = 1'b1;
            tag_nxt  = rx_tag_i;
            tagv_nxt = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // rs485 interval arbitration, time base in microseconds
   always_comb begin
      pre_nxt = (pre_r == 6'(pra_pkg::US_CYC - 1)) ? 6'd0 : pre_r + 6'd1;
      cnt_nxt = (line_s_r || sync_r || grant_r) ? 16'd0 :
                (tick && cnt_r != 16'hFFFF) ? cnt_r + 16'd1 : cnt_r;
      grant_nxt = ser_pending_i && (!coll_en || grant_r || (!line_s_r && cnt_r >= ival_r));
      sync_nxt  = opt_r[pra_pkg::OPT_SYNC_BIT] && ready && !sync_r;
      schar_nxt = sync_nxt ? pra_pkg::SYNC_CHAR : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         retry_r <= pra_pkg::RETRY_RST;
         ival_r  <= pra_pkg::IVAL_RST;
         opt_r   <= pra_pkg::OPT_RST;
         gsize_r <= pra_pkg::GSIZE_RST;
         dwell_r <= pra_pkg::DWELL_RST;
         rdata_o <= 32'h0000_0000;
         st_r    <= pra_pkg::ST_IDLE;
         tmr_r   <= 20'd0;
         left_r  <= 8'd0;
         bcast_r <= 1'b0;
         relay_r <= 1'b0;
         seen_r  <= 1'b0;
         freq_r  <= 5'd0;
         dwc_r   <= 16'd0;
         tag_r   <= 8'd0;
         tagv_r  <= 1'b0;
         busy_r  <= 1'b0;
         lfsr_r  <= pra_pkg::LFSR_RST;
         radio_tx_o <= 1'b0;
         ack_tx_o   <= 1'b0;
         deliver_o  <= 1'b0;
         success_response_o <= 1'b0;
         failure_response_o <= 1'b0;
         pre_r    <= 6'd0;
         cnt_r    <= 16'd0;
         line_m_r <= 1'b0;
         line_s_r <= 1'b0;
         grant_r  <= 1'b0;
         sync_r   <= 1'b0;
         sync_char_o <= 8'h00;
      end else begin
         retry_r <= retry_nxt;
         ival_r  <= ival_nxt;
         opt_r   <= opt_nxt;
         gsize_r <= gsize_nxt;
         dwell_r <= dwell_nxt;
         rdata_o <= rdata_nxt;
         st_r    <= st_nxt;
         tmr_r   <= tmr_nxt;
         left_r  <= left_nxt;
         bcast_r <= bcast_nxt;
         relay_r <= relay_nxt;
         seen_r  <= seen_nxt;
         freq_r  <= freq_nxt;
         dwc_r   <= dwc_nxt;
         tag_r   <= tag_nxt;
         tagv_r  <= tagv_nxt;
         busy_r  <= busy_nxt;
         lfsr_r  <= lfsr_nxt;
         radio_tx_o <= rtx_nxt;
         ack_tx_o   <= atx_nxt;
         deliver_o  <= dlv_nxt;
         success_response_o <= suc_nxt;
         failure_response_o <= fail_nxt;
         pre_r    <= pre_nxt;
         cnt_r    <= cnt_nxt;
         line_m_r <= line_act_i;
         line_s_r <= line_m_r;
         grant_r  <= grant_nxt;
         sync_r   <= sync_nxt;
         sync_char_o <= schar_nxt;
      end
   end

   assign freq_o      = freq_r;
   assign busy_o      = busy_r;
   assign ser_grant_o = grant_r;
   assign sync_o      = sync_r;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   property p_succ;
      success_response_o && !bcast_r |-> $past(ack_rx_i) && $past(st_r == pra_pkg::ST_ACKW);
   endproperty
   a_succ: assert property (p_succ) else $error("success without ack");
   property p_fail0;
      att_fail && left_r == 8'd0 && !ack_rx_i && !relay_r |=> failure_response_o && st_r == pra_pkg::ST_IDLE;
   endproperty
   a_fail0: assert property (p_fail0) else $error("no failure after last attempt");
   property p_retry;
      att_fail && left_r != 8'd0 && !ack_rx_i |=> st_r == pra_pkg::ST_RWAIT && left_r == $past(left_r) - 8'd1;
   endproperty
   a_retry: assert property (p_retry) else $error("retry not counted");
   property p_hop;
      att_fail && left_r != 8'd0 && !ack_rx_i && grp_en |=> freq_r == next_freq($past(freq_r), gsize_r);
   endproperty
   a_hop: assert property (p_hop) else $error("no hop on retry");
   property p_dup;
      rx_ok && dup |=> !deliver_o;
   endproperty
   a_dup: assert property (p_dup) else $error("duplicate delivered");
   property p_bcast;
      st_r == pra_pkg::ST_SEND && bcast_r |=> st_r != pra_pkg::ST_ACKW;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast waits for ack");
   property p_block;
      rx_pkt_i && bcast_r && busy_o |=> !deliver_o;
   endproperty
   a_block: assert property (p_block) else $error("rx during broadcast");
   property p_grant;
      coll_en && !grant_r && grant_nxt |-> cnt_r >= ival_r && !line_s_r;
   endproperty
   a_grant: assert property (p_grant) else $error("grant before interval");
   property p_sync;
      sync_o |-> sync_char_o == pra_pkg::SYNC_CHAR ##1 cnt_r == 16'd0;
   endproperty
   a_sync: assert property (p_sync) else $error("sync did not restart interval");
   property p_ackw;
      $rose(st_r == pra_pkg::ST_ACKW) |-> tmr_r == 20'(ACK_WAIT_CYC - 1);
   endproperty
   a_ackw: assert property (p_ackw) else $error("ack window wrong");

   c_succ: cover property (success_response_o && !bcast_r);
   c_fail: cover property (failure_response_o);
   c_bcast: cover property (success_response_o && bcast_r);
   c_sync: cover property (sync_o);
endmodule
`default_nettype wire

// ==== core/pra_pkg.sv ====
// shared constants and types for the packet retry and line arbiter
// Notes on behaviour
// - repeater forwards packet, then returns own ack
// - broadcast repeats count times, no ack wait
// - repeated broadcast copies are not delivered again
// - success on received acknowledgment packet, or after the last broadcast copy
// - first data reception: ack and deliver
// - retry zero: no ack gives failure, stop
// - retry n: resend until ack or n+1
// - duplicate data: ack but withhold delivery
// - ack gives success; exhaustion gives failure
// - retry from register or set command
// - sender steps group frequency each attempt
// - idle receiver cycles group, dwelling longer
// - collision enable holds output until interval
// - sync-enabled modem emits carriage return idle
// - line traffic restarts interval measurement
// - earlier foreign output defers own output
// - repeating broadcast sender drops incoming packets
// - random wait 0, 3, 6, 10 ms
// - ack must start within 5 ms
package pra_pkg;
   localparam int unsigned CLK_HZ      = 40_000_000;
   localparam int unsigned ACK_WAIT_MS = 5;
   localparam int unsigned RW_A_MS     = 3;
   localparam int unsigned RW_B_MS     = 6;
   localparam int unsigned RW_C_MS     = 10;
   localparam int unsigned ACK_WAIT_CYC = ACK_WAIT_MS * (CLK_HZ / 1000);
   localparam int unsigned RW_A_CYC     = RW_A_MS * (CLK_HZ / 1000);
   localparam int unsigned RW_B_CYC     = RW_B_MS * (CLK_HZ / 1000);
   localparam int unsigned RW_C_CYC     = RW_C_MS * (CLK_HZ / 1000);
   localparam int unsigned US_CYC       = CLK_HZ / 1_000_000;

   localparam logic [7:0] ADDR_RETRY  = 8'h00;
   localparam logic [7:0] ADDR_IVAL   = 8'h04;
   localparam logic [7:0] ADDR_OPT    = 8'h08;
   localparam logic [7:0] ADDR_GSIZE  = 8'h0C;
   localparam logic [7:0] ADDR_DWELL  = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   localparam int unsigned OPT_GRP_BIT  = 0;
   localparam int unsigned OPT_COLL_BIT = 1;
   localparam int unsigned OPT_SYNC_BIT = 2;

   localparam logic [7:0]  RETRY_RST = 8'h03;
   localparam logic [15:0] IVAL_RST  = 16'h0064;
   localparam logic [2:0]  OPT_RST   = 3'h0;
   localparam logic [4:0]  GSIZE_RST = 5'h01;
   localparam logic [15:0] DWELL_RST = 16'h2710;
   localparam logic [7:0]  LFSR_RST  = 8'hA5;
   localparam logic [7:0]  SYNC_CHAR = 8'h0D;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b0_0001,
      ST_RWAIT = 5'b0_0010,
      ST_CSNS  = 5'b0_0100,
      ST_SEND  = 5'b0_1000,
      ST_ACKW  = 5'b1_0000
   } pra_state_t;
endpackage

// ==== tb/pra_radio_peer.sv ====
// radio-side peer model: finishes each send and acks one chosen attempt
`timescale 1ns/1ps
`default_nettype none
module pra_radio_peer (
   input  wire logic       clk_i,        // clock
   input  wire logic       resetn_i,     // async reset, active low
   input  wire logic       radio_tx_i,   // send start from block
   input  wire logic       clr_i,        // clear attempt count
   input  wire logic [3:0] ack_on_i,     // attempt that is acked, 0 none
   output logic            radio_done_o, // airtime over
   output logic            ack_start_o,  // ack preamble
   output logic            ack_rx_o      // ack packet
);
   logic [3:0] att_r;
   logic [5:0] tm_r;
   logic       hit;
   assign hit          = (att_r == ack_on_i);
   assign radio_done_o = (tm_r == 6'h06);
   // preamble well inside the short ack window of the bench build
   assign ack_start_o  = (tm_r == 6'h0A) && hit;
   // a lost ack is modelled by acking none or a later attempt only
   assign ack_rx_o     = (tm_r == 6'h0C) && hit;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         att_r <= 4'h0;
         tm_r  <= 6'h00;
      end else begin
         if (clr_i) begin
            att_r <= 4'h0;
         end else if (radio_tx_i) begin
            att_r <= att_r + 4'h1;
         end
         if (radio_tx_i) begin
            tm_r <= 6'h01;
         end else if (tm_r == 6'h0D) begin
            tm_r <= 6'h00;
         end else if (tm_r != 6'h00) begin
            tm_r <= tm_r + 6'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/packet_arq_rs485_arbiter_tb.sv ====
// self-checking bench for the packet retry engine and line arbiter
`timescale 1ns/1ps
`default_nettype none
module packet_arq_rs485_arbiter_tb;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, sd = 0, sr = 0, bc = 0, rsc = 0, rf = 0, car = 0;
   logic rxp = 0, rxb = 0, la = 0, pend = 0, pclr = 0, tx, ackt, dlv, ok, fl, grant, sy, dn, ast, arx, bsy;
   logic [7:0]  addr = 0, rval = 0, tag = 0, sch;
   logic [31:0] wd = 0, rdat;
   logic [3:0]  ack_on = 0;
   logic [4:0]  frq;
   int n_mismatch = 0, tests_run = 0, n_tx, n_ok, n_fl, n_ack, n_dlv, n_sy;
   initial forever #12.5 clk = ~clk;
   pra_arq #(.ACK_WAIT_CYC(40), .RW_A_CYC(12), .RW_B_CYC(24), .RW_C_CYC(40)) dut (
      .clk_i(clk), .resetn_i(rstn), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
      .send_direct_cmd_i(sd), .send_via_relay_cmd_i(sr), .cmd_bcast_i(bc), .retry_set_cmd_i(rsc),
      .retry_val_i(rval), .relay_fwd_i(rf), .carrier_i(car), .radio_done_i(dn), .ack_start_i(ast),
      .ack_rx_i(arx), .ack_abort_i(1'b0), .rx_pkt_i(rxp), .rx_bcast_i(rxb), .rx_tag_i(tag),
      .line_act_i(la), .ser_pending_i(pend), .radio_tx_o(tx), .ack_tx_o(ackt), .deliver_o(dlv),
      .success_response_o(ok), .failure_response_o(fl), .freq_o(frq), .busy_o(bsy), .ser_grant_o(grant),
      .sync_o(sy), .sync_char_o(sch));
   pra_radio_peer peer (.clk_i(clk), .resetn_i(rstn), .radio_tx_i(tx), .clr_i(pclr), .ack_on_i(ack_on),
      .radio_done_o(dn), .ack_start_o(ast), .ack_rx_o(arx));
   always @(posedge clk) begin
      n_tx  <= n_tx + int'(tx);
      n_ok  <= n_ok + int'(ok);
      n_fl  <= n_fl + int'(fl);
      n_ack <= n_ack + int'(ackt);
      n_dlv <= n_dlv + int'(dlv);
      n_sy  <= n_sy + int'(sy);
      if (sy === 1'b1 && sch !== 8'h0D) begin
         n_mismatch <= n_mismatch + 1;
         $display("[FAIL] %0t sync character wrong", $time);
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %0h want %0h", $time, what, got, exp);
      end
   endtask
   task automatic clr();
      #1;
      {n_tx, n_ok, n_fl, n_ack, n_dlv, n_sy} = '0;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      wr <= 0;
      rd <= 0;
      #1;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
      bus(0, a, 0);
      chk(rdat & mask, exp, "register read");
   endtask
   task automatic end_of_test();
      $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // kind 0 direct, 1 via repeater command, 2 repeater forwarding job
   task automatic xfer(input int kind, input logic b, input logic [3:0] an, input int etx, input int eok,
                       input int efl, input int eack);
      clr();
      @(posedge clk);
      pclr <= 1;
      ack_on <= an;
      bc <= b;
      sd <= (kind == 0);
      sr <= (kind == 1);
      rf <= (kind == 2);
      @(posedge clk);
      {pclr, sd, sr, rf, bc} <= '0;
      #1 chk(bsy, 1'b1, "busy during transfer");
      repeat (3000) begin
         @(posedge clk);
         if (n_ok + n_fl + n_ack > 0) break;
      end
      repeat (200) @(posedge clk);
      chk(n_tx, etx, "send count");
      chk(n_ok, eok, "success count");
      chk(n_fl, efl, "failure count");
      chk(n_ack, eack, "ack count");
   endtask
   task automatic rx(input logic [7:0] t, input logic b, input int eack, input int edlv);
      clr();
      @(posedge clk);
      rxp <= 1;
      rxb <= b;
      tag <= t;
      @(posedge clk);
      rxp <= 0;
      repeat (4) @(posedge clk);
      chk(n_ack, eack, "rx ack count");
      chk(n_dlv, edlv, "rx delivery count");
   endtask
   initial begin
      #1500000;
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1;
      rdchk(8'h00, 32'hFF, 32'h3);
      rdchk(8'h04, 32'hFFFF, 32'h64);
      rdchk(8'h08, 32'h7, 32'h0);
      rdchk(8'h0C, 32'h1F, 32'h1);
      rdchk(8'h10, 32'hFFFF, 32'h2710);
      rdchk(8'h20, 32'hFFFF_FFFF, 32'h0);
      bus(1, 8'h14, 32'hFFFF_FFFF);
      rdchk(8'h14, 32'h3E000, 32'h2000);
      @(posedge clk);
      car <= 1'b1;
      fork
         begin
            repeat (60) @(posedge clk);
            car <= 1'b0;
         end
      join_none
      xfer(0, 0, 4'h1, 1, 1, 0, 0);
      bus(1, 8'h00, 32'h0);
      rdchk(8'h00, 32'hFF, 32'h0);
      xfer(0, 0, 4'h0, 1, 0, 1, 0);
      bus(1, 8'h00, 32'h2);
      xfer(0, 0, 4'h0, 3, 0, 1, 0);
      bus(1, 8'h0C, 32'h3);
      bus(1, 8'h08, 32'h1);
      @(posedge clk);
      rsc <= 1;
      rval <= 8'h9;
      @(posedge clk);
      rsc <= 0;
      xfer(1, 0, 4'h2, 2, 1, 0, 0);
      chk(frq, 32'h1, "hop index after one retry");
      bus(1, 8'h10, 32'h0);
      repeat (45) @(posedge clk);
      chk(frq != 5'd1, 1'b1, "idle receiver hop");
      bus(1, 8'h00, 32'h3);
      xfer(0, 1, 4'h1, 3, 1, 0, 0);
      xfer(2, 0, 4'h1, 1, 0, 0, 1);
      rx(8'h05, 0, 1, 1);
      rx(8'h05, 0, 1, 0);
      rx(8'h07, 1, 0, 1);
      rx(8'h07, 1, 0, 0);
      bus(1, 8'h04, 32'h2);
      bus(1, 8'h08, 32'h2);
      clr();
      @(posedge clk);
      la <= 1;
      repeat (3) @(posedge clk);
      pend <= 1;
      repeat (8) begin
         repeat (40) @(posedge clk);
         la <= ~la;
         #1 chk(grant, 1'b0, "grant during traffic");
      end
      @(posedge clk);
      la <= 0;
      repeat (200) @(posedge clk);
      chk(grant, 1'b1, "grant after quiet interval");
      pend <= 0;
      bus(1, 8'h08, 32'h6);
      repeat (300) @(posedge clk);
      chk(n_sy > 0, 1'b1, "periodic sync seen");
      end_of_test();
   end
endmodule
`default_nettype wire
